// *** operand_field_decoder.v ***
`timescale 1ns/10ps
`default_nettype none
`include "operand_field_defs.vh"

module operand_field_decoder
(
   input  wire        clk,
   input  wire        rst,
   input  wire        instr_valid,
   input  wire [3:0]  field_kind,
   input  wire [4:0]  reg_code,
   input  wire [4:0]  reg_code2,
   input  wire        reg_is_dest,
   input  wire        indexed_mode,
   input  wire [1:0]  mult_sign,
   input  wire [1:0]  imm_kind,
   input  wire [15:0] imm_raw,
   input  wire        dual_read,
   input  wire [1:0]  dual_op,
   input  wire [4:0]  alu_src,
   input  wire [4:0]  alu_dst,
   input  wire [4:0]  rd1_ptr,
   input  wire [1:0]  rd1_mode,
   input  wire [4:0]  rd1_dst,
   input  wire [4:0]  rd2_ptr,
   input  wire [1:0]  rd2_mode,
   input  wire [4:0]  rd2_dst,
   output reg         cycle_phase_reg,
   output reg         result_valid_reg,
   output reg         field_legal_reg,
   output reg         negate_product_reg,
   output reg         saturate_en_reg,
   output reg  [15:0] imm_value_reg,
   output reg         dual_legal_reg,
   output reg  [5:0]  dual_fault_reg,
   output reg         illegal_instr_reg
);

   wire        field_ok;
   wire        icyc_en;
   reg         sat_next;
   reg  [15:0] imm_next;
   reg  [5:0]  fault_next;

   function in_mask;
      input [31:0] mask;
      input [4:0]  code;
      begin
         in_mask = mask[code];
      end
   endfunction

   function is_acc;
      input [4:0] code;
      begin
         is_acc = in_mask(`MASK_ACC, code);
      end
   endfunction

   function is_data_reg;
      input [4:0] code;
      begin
         is_data_reg = in_mask(`MASK_DATA_REG, code);
      end
   endfunction

   reg_field_checker u_checker
   (
      .field_kind   (field_kind),
      .reg_code     (reg_code),
      .reg_code2    (reg_code2),
      .reg_is_dest  (reg_is_dest),
      .indexed_mode (indexed_mode),
      .legal        (field_ok)
   );

   // Instructions are taken once per instruction cycle, on the second clock of it.
   assign icyc_en = cycle_phase_reg;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cycle_phase_reg <= 1'b0;
      end
      else
      begin
         cycle_phase_reg <= ~cycle_phase_reg;
      end
   end

   // Saturation applies only when a full accumulator is read out by its
   // plain name; its upper-half name moves the bits unlimited.
   always @*
   begin
      sat_next = !reg_is_dest && is_acc(reg_code) &&
                 ((field_kind == `FLD_DATA_MOVE) || (field_kind == `FLD_EXT_MOVE) ||
                  (field_kind == `FLD_ALL_CPU)   || (field_kind == `FLD_ACC));
   end

   always @*
   begin
      case (imm_kind)
         `IMM_SHORT_MASK_IMMEDIATE:
         begin
            imm_next = {8'h00, imm_raw[`IMM_SHORT_MASK_IMMEDIATE_W-1:0]};
         end
         `IMM_LONG_MASK_IMMEDIATE:
         begin
            imm_next = imm_raw;
         end
         `IMM_RELATIVE_BRANCH_OFFSET:
         begin
            imm_next = {{9{imm_raw[`IMM_RELATIVE_BRANCH_OFFSET_W-1]}}, imm_raw[`IMM_RELATIVE_BRANCH_OFFSET_W-1:0]};
         end
         `IMM_ABSOLUTE_TARGET:
         begin
            imm_next = imm_raw;
         end
         default:
         begin
            imm_next = imm_raw;
         end
      endcase
   end

   // Fault bits: 0 operands, 1 first pointer, 2 first mode,
   // 3 first destination, 4 second pointer or mode, 5 second destination.
   always @*
   begin
      fault_next = 6'h00;
      if (dual_read)
      begin
         if ((dual_op == `DOP_ADD) || (dual_op == `DOP_SUB))
         begin
            fault_next[0] = !((is_data_reg(alu_src) && is_acc(alu_dst)) ||
                              (is_acc(alu_src) && is_acc(alu_dst) &&
                               (alu_src != alu_dst)));
         end
         fault_next[1] = !in_mask(`MASK_PTR_ONLY, rd1_ptr) ||
                         (rd1_ptr == `REG_PTR2) ||
                         (rd1_ptr == `REG_PTR3);
         fault_next[2] = (rd1_mode == `MODE_POST_DEC);
         fault_next[3] = !in_mask(`MASK_DUAL_DST1, rd1_dst);
         fault_next[4] = (rd2_ptr != `REG_PTR3) ||
                         !((rd2_mode == `MODE_POST_INC) ||
                           (rd2_mode == `MODE_POST_DEC));
         fault_next[5] = !in_mask(`MASK_DUAL_DST2, rd2_dst);
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         result_valid_reg   <= 1'b0;
         field_legal_reg    <= 1'b0;
         negate_product_reg <= 1'b0;
         saturate_en_reg    <= 1'b0;
         imm_value_reg      <= 16'h0000;
         dual_legal_reg     <= 1'b0;
         dual_fault_reg     <= 6'h00;
         illegal_instr_reg  <= 1'b0;
      end
      else
      begin
         result_valid_reg <= icyc_en && instr_valid;
         if (icyc_en && instr_valid)
         begin
            field_legal_reg    <= field_ok;
            negate_product_reg <= (mult_sign == `SIGN_MINUS);
            saturate_en_reg    <= sat_next;
            imm_value_reg      <= imm_next;
            dual_legal_reg     <= dual_read && (fault_next == 6'h00);
            dual_fault_reg     <= fault_next;
            illegal_instr_reg  <= !field_ok || (fault_next != 6'h00) ||
                                  (mult_sign == 2'h3);
         end
      end
   end

endmodule // operand_field_decoder
`default_nettype wire

// *** operand_field_defs.vh ***
// How it works
// - Data move field: A, B, A1, B1, X0, Y0, Y1.
// - Extended move adds four pointers and index.
// - Pointer-or-stack field: four pointers plus stack pointer.
// - Pointer-only field: four pointers, no stack pointer.
// - Index only when indexed; one modifier register.
// - Arith field: both accumulators and data registers.
// - Alt arith field: accumulator upper halves, data registers.
// - Accumulator field selects either full accumulator.
// - Accumulator pair legal only as A,B or B,A.
// - Accumulator upper-half field is source only.
// - Immediates: 8/16-bit masks, 7-bit offset, 16-bit address.
// - Minus sign negates the product; otherwise unchanged.
// - Accumulator naming decides move-source saturation.
// - Dual-read add/sub: data reg to acc, acc to the other acc.
// - First dual read rejects pointers two and three.
// - First dual read has no post-decrement.
// - Second dual read always uses pointer three.
// - Second dual read: post-increment or post-decrement only.
// - Each dual-read destination limited to its slot.
// - One instruction cycle equals two clock cycles.
`ifndef OPERAND_FIELD_DEFS_VH
`define OPERAND_FIELD_DEFS_VH

// Register codes presented by the fetch stage.
`define REG_ACC_A      5'h00
`define REG_ACC_B      5'h01
`define REG_A_UPPER    5'h02
`define REG_B_UPPER    5'h03
`define REG_A_EXT      5'h04
`define REG_A_LOWER    5'h05
`define REG_B_EXT      5'h06
`define REG_B_LOWER    5'h07
`define REG_XA         5'h08
`define REG_YLOW       5'h09
`define REG_YHIGH      5'h0a
`define REG_PTR0       5'h0b
`define REG_PTR1       5'h0c
`define REG_PTR2       5'h0d
`define REG_PTR3       5'h0e
`define REG_INDEX      5'h0f
`define REG_STACK      5'h10
`define REG_MODIFIER   5'h11
`define REG_OPMODE     5'h12
`define REG_STATUS     5'h13
`define REG_LOOP_ADDR  5'h14
`define REG_LOOP_CNT   5'h15
`define REG_HW_STACK   5'h16

// Field kinds.
`define FLD_DATA_MOVE  4'h0
`define FLD_EXT_MOVE   4'h1
`define FLD_ALL_CPU    4'h2
`define FLD_PTR_STACK  4'h3
`define FLD_PTR_ONLY   4'h4
`define FLD_INDEX      4'h5
`define FLD_MODIFIER   4'h6
`define FLD_ARITH      4'h7
`define FLD_ALT_ARITH  4'h8
`define FLD_DATA_REG   4'h9
`define FLD_ACC        4'ha
`define FLD_ACC_MSP    4'hb
`define FLD_ACC_PAIR   4'hc

// Membership masks, one bit per register code.
`define MASK_DATA_MOVE 32'h0000070f
`define MASK_EXT_MOVE  32'h0000ff0f
`define MASK_ALL_CPU   32'h007fffff
`define MASK_PTR_STACK 32'h00017800
`define MASK_PTR_ONLY  32'h00007800
`define MASK_INDEX     32'h00008000
`define MASK_MODIFIER  32'h00020000
`define MASK_ARITH     32'h00000703
`define MASK_ALT_ARITH 32'h0000070c
`define MASK_DATA_REG  32'h00000700
`define MASK_ACC       32'h00000003
`define MASK_ACC_MSP   32'h0000000c
`define MASK_DUAL_DST1 32'h00000600
`define MASK_DUAL_DST2 32'h00000100

// Addressing post-update modes.
`define MODE_NONE      2'h0
`define MODE_POST_INC  2'h1
`define MODE_POST_DEC  2'h2
`define MODE_POST_IDX  2'h3

// Multiply sign.
`define SIGN_NONE      2'h0
`define SIGN_PLUS      2'h1
`define SIGN_MINUS     2'h2

// Immediate kinds and widths.
`define IMM_SHORT_MASK_IMMEDIATE      2'h0
`define IMM_LONG_MASK_IMMEDIATE     2'h1
`define IMM_RELATIVE_BRANCH_OFFSET    2'h2
`define IMM_ABSOLUTE_TARGET      2'h3
`define IMM_SHORT_MASK_IMMEDIATE_W    8
`define IMM_RELATIVE_BRANCH_OFFSET_W  7

// Dual-read arithmetic operation.
`define DOP_MOVE       2'h0
`define DOP_ADD        2'h1
`define DOP_SUB        2'h2
`define DOP_MULT       2'h3

// Clock cycles per instruction cycle.
`define CLKS_PER_ICYC  2

`endif

// *** reg_field_checker.v ***
`timescale 1ns/10ps
`default_nettype none
`include "operand_field_defs.vh"

module reg_field_checker
(
   input  wire [3:0] field_kind,
   input  wire [4:0] reg_code,
   input  wire [4:0] reg_code2,
   input  wire       reg_is_dest,
   input  wire       indexed_mode,
   output reg        legal
);

   function [31:0] field_mask;
      input [3:0] kind;
      begin
         case (kind)
            `FLD_DATA_MOVE: field_mask = `MASK_DATA_MOVE;
            `FLD_EXT_MOVE:  field_mask = `MASK_EXT_MOVE;
            `FLD_ALL_CPU:   field_mask = `MASK_ALL_CPU;
            `FLD_PTR_STACK: field_mask = `MASK_PTR_STACK;
            `FLD_PTR_ONLY:  field_mask = `MASK_PTR_ONLY;
            `FLD_INDEX:     field_mask = `MASK_INDEX;
            `FLD_MODIFIER:  field_mask = `MASK_MODIFIER;
            `FLD_ARITH:     field_mask = `MASK_ARITH;
            `FLD_ALT_ARITH: field_mask = `MASK_ALT_ARITH;
            `FLD_DATA_REG:  field_mask = `MASK_DATA_REG;
            `FLD_ACC:       field_mask = `MASK_ACC;
            `FLD_ACC_MSP:   field_mask = `MASK_ACC_MSP;
            `FLD_ACC_PAIR:  field_mask = `MASK_ACC;
            default:        field_mask = 32'h00000000;
         endcase
      end
   endfunction

   always @*
   begin
      legal = |(field_mask(field_kind) & (32'h00000001 << reg_code));
      if (field_kind == `FLD_ACC_PAIR)
      begin
         legal = ((reg_code == `REG_ACC_A) && (reg_code2 == `REG_ACC_B)) ||
                 ((reg_code == `REG_ACC_B) && (reg_code2 == `REG_ACC_A));
      end
      if ((field_kind == `FLD_ACC_MSP) && reg_is_dest)
      begin
         legal = 1'b0;
      end
      if ((field_kind == `FLD_INDEX) && !indexed_mode)
      begin
         legal = 1'b0;
      end
   end

endmodule // reg_field_checker
`default_nettype wire

// *** operand_field_decoder_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "operand_field_defs.vh"
module operand_field_decoder_properties
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        instr_valid,
   input wire logic [1:0]  mult_sign,
   input wire logic [1:0]  imm_kind,
   input wire logic [15:0] imm_raw,
   input wire logic        dual_read,
   input wire logic        cycle_phase_reg,
   input wire logic        result_valid_reg,
   input wire logic        field_legal_reg,
   input wire logic        negate_product_reg,
   input wire logic [15:0] imm_value_reg,
   input wire logic        dual_legal_reg,
   input wire logic [5:0]  dual_fault_reg,
   input wire logic        illegal_instr_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire take = cycle_phase_reg && instr_valid;
   a_phase_toggle: assert property (cycle_phase_reg |=>
      !cycle_phase_reg ##1 cycle_phase_reg) else $error("phase not alternating");
   a_take_answer: assert property (take |=>
      result_valid_reg ##1 !result_valid_reg) else $error("answer pulse wrong");
   a_no_answer: assert property (!take |=> !result_valid_reg)
      else $error("answer without take");
   a_neg_product: assert property (take |=>
      negate_product_reg == ($past(mult_sign) == `SIGN_MINUS)) else $error("negate wrong");
   a_imm_short: assert property (take && imm_kind == `IMM_SHORT_MASK_IMMEDIATE |=>
      imm_value_reg == {8'h00, $past(imm_raw[7:0])}) else $error("short mask wrong");
   a_imm_offset: assert property (take && imm_kind == `IMM_RELATIVE_BRANCH_OFFSET |=>
      imm_value_reg == {{9{$past(imm_raw[6])}}, $past(imm_raw[6:0])})
      else $error("offset extension wrong");
   a_dual_idle: assert property (take && !dual_read |=>
      dual_fault_reg == 6'h00 && !dual_legal_reg) else $error("dual flags without dual read");
   a_illegal_flag: assert property (take |=> illegal_instr_reg ==
      (!field_legal_reg || dual_fault_reg != 6'h00 || $past(mult_sign) == 2'h3))
      else $error("illegal flag wrong");
   c_dual: cover property (take && dual_read);
   c_minus: cover property (take && mult_sign == `SIGN_MINUS);
   c_offset: cover property (take && imm_kind == `IMM_RELATIVE_BRANCH_OFFSET);
endmodule // operand_field_decoder_properties
bind operand_field_decoder operand_field_decoder_properties u_props (.*);
`default_nettype wire

// *** instr_fetch_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module instr_fetch_model
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic cycle_phase_reg,
   input  wire logic load,
   output var  logic instr_valid,
   output var  logic taken
);
   // An instruction waits until an accepting edge takes it, one per instruction cycle.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         instr_valid <= 1'b0;
         taken       <= 1'b0;
      end
      else
      begin
         taken       <= instr_valid && cycle_phase_reg;
         instr_valid <= load || (instr_valid && !cycle_phase_reg);
      end
   end
endmodule // instr_fetch_model
`default_nettype wire

// *** test_operand_field_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_operand_field_decoder;
   wire logic        cycle_phase_reg, result_valid_reg, field_legal_reg, negate_product_reg;
   wire logic        saturate_en_reg, dual_legal_reg, illegal_instr_reg, instr_valid, taken;
   wire logic [15:0] imm_value_reg;
   wire logic [5:0]  dual_fault_reg;
   logic             clk, rst, load, reg_is_dest, indexed_mode, dual_read;
   logic [3:0]       field_kind;
   logic [4:0]       reg_code, reg_code2, alu_src, alu_dst, rd1_ptr, rd1_dst, rd2_ptr, rd2_dst;
   logic [1:0]       mult_sign, imm_kind, dual_op, rd1_mode, rd2_mode;
   logic [15:0]      imm_raw;
   logic [5:0]       exp;
   integer           bad_count, tests_run, i;
   // Row: field kind, code, second code, dest, indexed, legal, saturate.
   logic [17:0] rows [0:19] = '{
      {4'h0, 5'h00, 9'h003},
      {4'h0, 5'h02, 9'h002},
      {4'h0, 5'h0b, 9'h000},
      {4'h0, 5'h00, 9'h00a},
      {4'h1, 5'h0f, 9'h002},
      {4'h1, 5'h10, 9'h000},
      {4'h3, 5'h10, 9'h002},
      {4'h4, 5'h10, 9'h000},
      {4'h5, 5'h0f, 9'h006},
      {4'h5, 5'h0f, 9'h000},
      {4'h7, 5'h01, 9'h002},
      {4'h7, 5'h02, 9'h000},
      {4'h8, 5'h03, 9'h002},
      {4'h8, 5'h00, 9'h000},
      {4'ha, 5'h01, 9'h003},
      {4'ha, 5'h08, 9'h000},
      {4'hc, 5'h01, 9'h002},
      {4'hc, 5'h01, 9'h010},
      {4'hb, 5'h03, 9'h002},
      {4'hb, 5'h03, 9'h008}};
   operand_field_decoder u_dut (.*);
   instr_fetch_model u_fetch (.clk(clk), .rst(rst), .cycle_phase_reg(cycle_phase_reg),
      .load(load), .instr_valid(instr_valid), .taken(taken));
   always #5 clk = ~clk;
   task test_done;
   begin
      if (bad_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task cmp(input logic [15:0] got, input logic [15:0] want);
   begin
      tests_run = tests_run + 1;
      if (got !== want)
      begin
         bad_count = bad_count + 1;
         $display("mismatch %0t got %h exp %h", $time, got, want);
      end
   end
   endtask
   task issue;
      integer n;
   begin
      @(posedge clk) #1 load = 1'b1;
      @(posedge clk) #1 load = 1'b0;
      for (n = 0; n < 9 && taken !== 1'b1; n++) @(posedge clk) #1;
      if (taken !== 1'b1)
      begin
         bad_count = bad_count + 1;
         test_done;
      end
   end
   endtask
   task zero;
   begin
      cmp({result_valid_reg, field_legal_reg, negate_product_reg, saturate_en_reg,
         dual_legal_reg, dual_fault_reg, illegal_instr_reg, cycle_phase_reg}, 16'h0000);
      cmp(imm_value_reg, 16'h0000);
   end
   endtask
   // Legal dual-read add; scenarios 2 to 8 each break one part of it.
   task dbase;
   begin
      {alu_src, alu_dst, rd1_ptr, rd1_dst, rd2_ptr, rd2_dst} =
         {5'h08, 5'h00, 5'h0b, 5'h09, 5'h0e, 5'h08};
      {dual_read, dual_op, rd1_mode, rd2_mode} = {1'b1, 2'h1, 2'h1, 2'h2};
   end
   endtask
   initial
   begin
      clk = 1'b0;
      {rst, load, reg_is_dest, indexed_mode, dual_read} = 5'h10;
      {field_kind, reg_code, reg_code2, mult_sign, imm_kind, imm_raw} = '0;
      {dual_op, rd1_mode, rd2_mode, alu_src, alu_dst, rd1_ptr, rd1_dst, rd2_ptr, rd2_dst} = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (15) @(posedge clk);
      #1 zero;
      @(posedge clk) #1 rst = 1'b0;
      @(posedge clk) #1 cmp(cycle_phase_reg, 1'b1);
      for (i = 0; i < 20; i++)
      begin
         {field_kind, reg_code, reg_code2, reg_is_dest, indexed_mode} = rows[i][17:2];
         issue;
         cmp(result_valid_reg, 1'b1);
         cmp(field_legal_reg, rows[i][1]);
         cmp(illegal_instr_reg, !rows[i][1]);
         cmp(saturate_en_reg, rows[i][0]);
      end
      {field_kind, reg_code, reg_code2, reg_is_dest, indexed_mode} = rows[0][17:2];
      imm_raw = 16'hc0c5;
      for (i = 0; i < 4; i++)
      begin
         {mult_sign, imm_kind} = {i[1:0], i[1:0]};
         issue;
         cmp(negate_product_reg, i == 2);
         cmp(illegal_instr_reg, i == 3);
         cmp(imm_value_reg, i == 0 ? 16'h00c5 : i == 2 ? 16'hffc5 : 16'hc0c5);
      end
      mult_sign = 2'h0;
      for (i = 0; i < 11; i++)
      begin
         dbase;
         dual_op = i[0] ? 2'h2 : 2'h1;
         case (i)
            1: alu_src = 5'h01;
            2: alu_src = 5'h00;
            3: rd1_ptr = 5'h0d;
            4: rd1_mode = 2'h2;
            5: rd1_dst = 5'h08;
            6: rd2_mode = 2'h3;
            7: rd2_dst = 5'h09;
            8: rd2_ptr = 5'h0c;
            9: {dual_op, alu_src} = {2'h3, 5'h00};
            default: {dual_op, alu_src} = {2'h0, 5'h00};
         endcase
         issue;
         exp = (i < 2 || i > 8) ? 6'h00 : (i == 8) ? 6'h10 : 6'h01 << (i - 2);
         cmp(dual_fault_reg, exp);
         cmp(dual_legal_reg, exp == 6'h00);
         cmp(illegal_instr_reg, exp != 6'h00);
      end
      rst = 1'b1;
      #2 zero;
      @(posedge clk) #1 rst = 1'b0;
      @(posedge clk) #1 cmp(cycle_phase_reg, 1'b1);
      issue;
      cmp(dual_legal_reg, 1'b1);
      @(posedge clk) #1 cmp(result_valid_reg, 1'b0);
      test_done;
   end
endmodule // test_operand_field_decoder
`default_nettype wire
